// file: sdcc_card_model.sv
// Purpose: behavioural card on the command line
// Assumes: card clock stops between frames only when the host stops it
// Notes  : line pulled up whenever nobody drives it
`timescale 1ns/1ps
module sdcc_card_model (
   input  wire logic         cclk,       // card clock
   input  wire logic         host_bit,   // host drive value
   input  wire logic         host_oe_n,  // host enable, low drives
   input  wire logic         reply_en,   // answer the frame
   input  wire logic [135:0] reply,      // reply frame, lsb last
   input  wire logic [7:0]   reply_len,  // reply length in bits
   input  wire logic [7:0]   gap,        // clocks before reply
   output wire logic         cmd_line,   // resolved line
   output logic      [47:0]  got_frame,  // last host frame
   output int                n_frames    // frames seen
);
   logic drv = 1'b0;
   logic val = 1'b1;
   assign cmd_line = !host_oe_n ? host_bit : (drv ? val : 1'b1);
   initial begin
      n_frames = 0;
      got_frame = 48'h0;
      forever begin
         @(posedge cclk iff (!host_oe_n && !host_bit));
         got_frame[47] = 1'b0;
         for (int i = 46; i >= 0; i--) begin
            @(posedge cclk);
            got_frame[i] = host_bit;
         end
         n_frames++;
         if (reply_en) begin
            repeat (gap) @(negedge cclk);
            // bits change on falling edges so the host samples them settled
            for (int i = reply_len - 1; i >= 0; i--) begin
               @(negedge cclk);
               drv = 1'b1;
               val = reply[i];
            end
            @(negedge cclk);
            drv = 1'b0;
         end
      end
   end
endmodule

// file: sdcc_cmd_clk.v
// Purpose : command issue, card clock update and self-clearing resets of a card host
// Assumes : sys_clk 25 MHz, synchronous active-low reset, classic wishbone slave
// Notes   : data path, dma and fifo movement live elsewhere; only their resets leave here
// Contract
// - clock settings applied only on update-clocks command
// - update done clears start and update, silent
// - idle accepts command; busy puts it in buffer
// - third command sets lock error, not loaded
// - wait flag holds command until data idle
// - low power stops card clock after nine idle
// - controller reset bit resets core, self-clears
// - fifo reset bit pulses fifo reset, self-clears
// - dma reset bit pulses dma reset, self-clears
// - command built from command and argument, sent
// - command done on response, on timeout, or after the frame when no response is expected
// - short response word 0, long fills four
// - separate timeout, crc and fault status bits
// - start flag returns 0 once committed
// - command fields, length 1 means 136-bit
// - crc check flag verifies response crc
`timescale 1ns/1ps
`include "sdcc_regs.vh"

module sdcc_cmd_clk (
   input  wire        sys_clk,    // controller clock
   input  wire        rst_n,      // synchronous reset, active low
   input  wire        wb_cyc_i,   // wishbone cycle
   input  wire        wb_stb_i,   // wishbone strobe
   input  wire        wb_we_i,    // wishbone write
   input  wire [7:0]  wb_adr_i,   // byte address
   input  wire [3:0]  wb_sel_i,   // byte lanes
   input  wire [31:0] wb_dat_i,   // write data
   output reg  [31:0] wb_dat_o,   // read data
   output reg         wb_ack_o,   // acknowledge
   input  wire        data_busy,  // data transfer in progress
   input  wire        cmd_in,     // card command line level
   output reg         cmd_out,    // command line drive value
   output reg         cmd_oe_n,   // command line enable, low drives
   output reg         cclk_out,   // card clock
   output reg  [1:0]  clk_src,    // working clock source
   output reg         fifo_rst,   // fifo pointer reset pulse
   output reg         dma_rst     // dma reset pulse
);

   localparam ST_IDLE = 3'h0;
   localparam ST_WAIT = 3'h1;
   localparam ST_TX   = 3'h2;
   localparam ST_RXW  = 3'h3;
   localparam ST_RX   = 3'h4;
   localparam ST_DONE = 3'h5;

   // ==========================================================
   // crc7 over a 40-bit command head
   function [6:0] crc7;
      input [39:0] m;
      integer i;
      reg [6:0] c;
      reg       fb;
      begin
         c = 7'h00;
         for (i = 39; i >= 0; i = i - 1) begin
            fb = c[6] ^ m[i];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
         end
         crc7 = c;
      end
   endfunction

   // ==========================================================
   // registers
   reg [2:0]   ctrl_q;
   reg [7:0]   clkdiv_q, div_work_q, div_cnt_q;
   reg [1:0]   clksrc_q;
   reg [31:0]  clkena_q, ena_work_q;
   reg [31:0]  arg_q, cmd_q;
   reg [31:0]  buf_cmd_q, buf_arg_q, ex_cmd_q, ex_arg_q;
   reg         buf_v_q, ex_v_q;
   reg [2:0]   st_q;
   reg [127:0] resp_q;
   reg [31:0]  rint_q;
   reg         ph_q;
   reg [3:0]   idle_q;
   reg [47:0]  tx_q;
   reg [7:0]   cnt_q, init_q;
   reg [135:0] rx_q;
   reg [6:0]   rcrc_q;

   wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr    = req & wb_we_i;
   wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wdat  = wb_dat_i & bmask;
   wire cmd_wr = wr & (wb_adr_i == `SDCC_A_CMD) & wb_sel_i[3]
                 & wb_dat_i[`SDCC_CMD_START];
   wire core_rst = ~rst_n | ctrl_q[`SDCC_CTRL_CTL_RST];

   // ==========================================================
   // card clock divider and gating
   // low power only gates while nothing is on the command line
   wire cmd_active = (st_q == ST_TX) | (st_q == ST_RXW) | (st_q == ST_RX);
   wire lp_stop    = ena_work_q[`SDCC_ENA_LOWPWR] & ~cmd_active & (idle_q > `SDCC_IDLE_STOP);
   wire clk_run    = ena_work_q[`SDCC_ENA_CCLK] & ~lp_stop;
   wire toggle     = (div_cnt_q == div_work_q);
   wire rise_t     = clk_run & toggle & ~ph_q;
   wire fall_t     = clk_run & toggle & ph_q;

   always @(posedge sys_clk) begin
      if (core_rst) begin
         div_cnt_q <= 8'h00;
         ph_q      <= 1'b0;
         cclk_out  <= 1'b0;
         idle_q    <= 4'h0;
      end else begin
         div_cnt_q <= toggle ? 8'h00 : div_cnt_q + 8'h01;
         if (toggle)
            ph_q <= ~ph_q;
         cclk_out <= clk_run & (toggle ? ~ph_q : ph_q);
         if (cmd_active | ~ena_work_q[`SDCC_ENA_LOWPWR])
            idle_q <= 4'h0;
         else if ((rise_t | lp_stop) && idle_q <= `SDCC_IDLE_STOP)
            idle_q <= idle_q + 4'h1;
      end
   end

   // ==========================================================
   // wishbone slave, one-cycle answer
   always @(posedge sys_clk) begin
      if (~rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            case (wb_adr_i)
               `SDCC_A_CTRL:    wb_dat_o <= {29'h0, ctrl_q};
               `SDCC_A_CLKDIV:  wb_dat_o <= {24'h0, clkdiv_q};
               `SDCC_A_CLKSRC:  wb_dat_o <= {30'h0, clksrc_q};
               `SDCC_A_CLKENA:  wb_dat_o <= clkena_q;
               `SDCC_A_CMDARG:  wb_dat_o <= arg_q;
               `SDCC_A_CMD:     wb_dat_o <= cmd_q;
               `SDCC_A_RESPONSE_WORD_0:   wb_dat_o <= resp_q[31:0];
               `SDCC_A_RESP1:   wb_dat_o <= resp_q[63:32];
               `SDCC_A_RESP2:   wb_dat_o <= resp_q[95:64];
               `SDCC_A_RESPONSE_WORD_3:   wb_dat_o <= resp_q[127:96];
               `SDCC_A_RINTSTS: wb_dat_o <= rint_q;
               `SDCC_A_STATUS:  wb_dat_o <= {25'h0, st_q, clk_run, data_busy, buf_v_q, ex_v_q};
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // self-clearing resets: held one cycle, then dropped
   always @(posedge sys_clk) begin
      if (~rst_n) begin
         ctrl_q   <= 3'h0;
         fifo_rst <= 1'b0;
         dma_rst  <= 1'b0;
      end else begin
         fifo_rst <= ctrl_q[`SDCC_CTRL_FIFO_RST];
         dma_rst  <= ctrl_q[`SDCC_CTRL_DMA_RST];
         if (wr && wb_adr_i == `SDCC_A_CTRL && wb_sel_i[0])
            ctrl_q <= wb_dat_i[2:0];
         else
            ctrl_q <= 3'h0;
      end
   end

   // ==========================================================
   // software settings registers
   always @(posedge sys_clk) begin
      if (~rst_n) begin
         clkdiv_q <= `SDCC_RST_CLKDIV;
         clksrc_q <= `SDCC_RST_CLKSRC;
         clkena_q <= 32'h0000_0000;
         arg_q    <= 32'h0000_0000;
      end else if (wr) begin
         case (wb_adr_i)
            `SDCC_A_CLKDIV: clkdiv_q <= wb_sel_i[0] ? wb_dat_i[7:0] : clkdiv_q;
            `SDCC_A_CLKSRC: clksrc_q <= wb_sel_i[0] ? wb_dat_i[1:0] : clksrc_q;
            `SDCC_A_CLKENA: clkena_q <= (clkena_q & ~bmask) | wdat;
            `SDCC_A_CMDARG: arg_q    <= (arg_q & ~bmask) | wdat;
            default:        clkena_q <= clkena_q;
         endcase
      end
   end

   // ==========================================================
   // command queue, executor and response capture
   wire        ld_ex   = ~ex_v_q & (buf_v_q | cmd_wr);
   wire [31:0] nxt_cmd = buf_v_q ? buf_cmd_q : wb_dat_i;
   wire [31:0] nxt_arg = buf_v_q ? buf_arg_q : arg_q;
   wire        long_r  = ex_cmd_q[`SDCC_CMD_RESP_LONG];
   wire [7:0]  rx_len  = long_r ? `SDCC_LONG_BITS : `SDCC_FRAME_BITS;
   wire [7:0]  rx_pos  = rx_len - cnt_q;
   wire        crc_in  = long_r ? (rx_pos >= 8'h08 && rx_pos < 8'h87)
                                : (rx_pos < 8'h2F);
   wire        crc_fb  = rcrc_q[6] ^ cmd_in;
   wire [6:0]  crc_nx  = {rcrc_q[5:0], 1'b0} ^ (crc_fb ? 7'h09 : 7'h00);
   wire [5:0]  idx     = ex_cmd_q[`SDCC_CMD_IDX_HI:0];
   reg  [31:0] rint_set;

   always @* begin
      rint_set = 32'h0000_0000;
      if (ex_v_q & ~buf_v_q & cmd_wr & ~ld_ex)
         rint_set[`SDCC_RI_HLE] = 1'b0;
      if (ex_v_q & buf_v_q & cmd_wr)
         rint_set[`SDCC_RI_HLE] = 1'b1;
      if (st_q == ST_RXW && rise_t && cnt_q == 8'h00)
         rint_set[`SDCC_RI_RTO] = 1'b1;
      if (st_q == ST_RX && rise_t && cnt_q == 8'h01) begin
         if (~cmd_in)
            rint_set[`SDCC_RI_FAULT] = 1'b1;
         if (ex_cmd_q[`SDCC_CMD_CHK_CRC] && rcrc_q != 7'h00)
            rint_set[`SDCC_RI_RCRC] = 1'b1;
      end
      if (st_q == ST_DONE && ~ex_cmd_q[`SDCC_CMD_UPD_CLK])
         rint_set[`SDCC_RI_DONE] = 1'b1;
   end

   always @(posedge sys_clk) begin
      if (~rst_n) begin
         rint_q <= 32'h0000_0000;
      end else begin
         // a new event wins over a clear in the same cycle
         if (wr && wb_adr_i == `SDCC_A_RINTSTS)
            rint_q <= (rint_q & ~wdat) | rint_set;
         else
            rint_q <= rint_q | rint_set;
      end
   end

   always @(posedge sys_clk) begin
      if (core_rst) begin
         cmd_q      <= 32'h0000_0000;
         buf_cmd_q  <= 32'h0000_0000;
         buf_arg_q  <= 32'h0000_0000;
         ex_cmd_q   <= 32'h0000_0000;
         ex_arg_q   <= 32'h0000_0000;
         buf_v_q    <= 1'b0;
         ex_v_q     <= 1'b0;
         st_q       <= ST_IDLE;
         resp_q     <= 128'h0;
         tx_q       <= 48'h0;
         cnt_q      <= 8'h00;
         init_q     <= 8'h00;
         rx_q       <= 136'h0;
         rcrc_q     <= 7'h00;
         cmd_out    <= 1'b1;
         cmd_oe_n   <= 1'b1;
         div_work_q <= `SDCC_RST_CLKDIV;
         clk_src    <= `SDCC_RST_CLKSRC;
         ena_work_q <= 32'h0000_0000;
      end else begin
         if (cmd_wr & ~(ex_v_q & buf_v_q))
            cmd_q <= wb_dat_i;
         if (cmd_wr & ex_v_q & ~buf_v_q) begin
            buf_cmd_q <= wb_dat_i;
            buf_arg_q <= arg_q;
            buf_v_q   <= 1'b1;
         end
         if (ld_ex) begin
            ex_cmd_q <= nxt_cmd;
            ex_arg_q <= nxt_arg;
            ex_v_q   <= 1'b1;
            st_q     <= ST_WAIT;
            if (buf_v_q)
               buf_v_q <= cmd_wr;
            if (buf_v_q & cmd_wr) begin
               buf_cmd_q <= wb_dat_i;
               buf_arg_q <= arg_q;
            end
            if (~nxt_cmd[`SDCC_CMD_UPD_CLK])
               cmd_q[`SDCC_CMD_START] <= 1'b0;
         end
         case (st_q)
            ST_IDLE: begin
               cmd_oe_n <= 1'b1;
            end
            ST_WAIT: begin
               if (~(ex_cmd_q[`SDCC_CMD_WAIT_PRV] & data_busy)) begin
                  if (ex_cmd_q[`SDCC_CMD_UPD_CLK]) begin
                     div_work_q <= clkdiv_q;
                     clk_src    <= clksrc_q;
                     ena_work_q <= clkena_q;
                     st_q       <= ST_DONE;
                  end else begin
                     tx_q   <= {2'b01, idx, ex_arg_q, crc7({2'b01, idx, ex_arg_q}), 1'b1};
                     cnt_q  <= `SDCC_FRAME_BITS;
                     init_q <= ex_cmd_q[`SDCC_CMD_SEND_INIT] ? `SDCC_INIT_CCLK : 8'h00;
                     st_q   <= ST_TX;
                  end
               end
            end
            ST_TX: begin
               // change on the falling edge so the card samples a settled level
               if (fall_t) begin
                  cmd_oe_n <= 1'b0;
                  if (init_q != 8'h00) begin
                     init_q  <= init_q - 8'h01;
                     cmd_out <= 1'b1;
                  end else if (cnt_q != 8'h00) begin
                     cmd_out <= tx_q[47];
                     tx_q    <= {tx_q[46:0], 1'b1};
                     cnt_q   <= cnt_q - 8'h01;
                  end else begin
                     cmd_oe_n <= 1'b1;
                     cmd_out  <= 1'b1;
                     cnt_q    <= `SDCC_RTO_CCLK;
                     st_q     <= ex_cmd_q[`SDCC_CMD_RESP_EXP] ? ST_RXW : ST_DONE;
                  end
               end
            end
            ST_RXW: begin
               if (rise_t) begin
                  if (~cmd_in) begin
                     rx_q   <= 136'h0;
                     rcrc_q <= 7'h00;                 // a zero start bit keeps a cleared crc at zero
                     cnt_q  <= rx_len - 8'h01;
                     st_q   <= ST_RX;
                  end else if (cnt_q == 8'h00) begin
                     st_q <= ST_DONE;
                  end else begin
                     cnt_q <= cnt_q - 8'h01;
                  end
               end
            end
            ST_RX: begin
               if (rise_t) begin
                  rx_q  <= {rx_q[134:0], cmd_in};
                  cnt_q <= cnt_q - 8'h01;
                  if (crc_in)
                     rcrc_q <= crc_nx;
                  if (cnt_q == 8'h01) begin
                     if (long_r)
                        resp_q <= {rx_q[126:0], cmd_in};
                     else
                        resp_q <= {96'h0, rx_q[38:7]};
                     st_q <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               ex_v_q <= 1'b0;
               st_q   <= ST_IDLE;
               if (ex_cmd_q[`SDCC_CMD_UPD_CLK] && ~buf_v_q) begin
                  cmd_q[`SDCC_CMD_START]   <= 1'b0;
                  cmd_q[`SDCC_CMD_UPD_CLK] <= 1'b0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule

// file: sdcc_cmd_clk_asserts.sv
// Purpose: port-level checks of the card command/clock block
// Assumes: one clock, synchronous active-low reset
// Notes  : attached by bind below the module
`timescale 1ns/1ps
module sdcc_cmd_clk_asserts (
   input logic        sys_clk,   // controller clock
   input logic        rst_n,     // reset, active low
   input logic        wb_cyc_i,  // cycle
   input logic        wb_stb_i,  // strobe
   input logic        wb_we_i,   // write
   input logic [7:0]  wb_adr_i,  // address
   input logic [3:0]  wb_sel_i,  // lanes
   input logic [31:0] wb_dat_i,  // write data
   input logic [31:0] wb_dat_o,  // read data
   input logic        wb_ack_o,  // ack
   input logic [1:0]  clk_src,   // working source
   input logic        fifo_rst,  // fifo reset pulse
   input logic        dma_rst    // dma reset pulse
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctl_wr = take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
   // ==========================================================
   // assertions
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_prompt: assert property (take |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
      else $error("ack without a request");
   a_fifo_pulse: assert property (ctl_wr && wb_dat_i[1] |-> ##[1:3] fifo_rst)
      else $error("fifo reset pulse missing");
   a_dma_pulse: assert property (ctl_wr && wb_dat_i[2] |-> ##[1:3] dma_rst)
      else $error("dma reset pulse missing");
   a_reset_self_clear: assert property (fifo_rst || dma_rst |=> !fifo_rst && !dma_rst)
      else $error("reset pulse stuck high");
   a_src_held: assert property (take && wb_we_i && wb_adr_i == 8'h0C |=> $stable(clk_src)[*2])
      else $error("clock source changed without update");
   a_ctl_clears_src: assert property (ctl_wr && wb_dat_i[0] |-> ##[1:3] clk_src == 2'h0)
      else $error("controller reset left clock source");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h04 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   c_ctl_reset: cover property (ctl_wr && wb_dat_i[0]);
   c_src_change: cover property (!$stable(clk_src));
   c_fifo_pulse: cover property (fifo_rst);
endmodule
bind sdcc_cmd_clk sdcc_cmd_clk_asserts sdcc_cmd_clk_asserts_i (.sys_clk(sys_clk),
   .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .clk_src(clk_src), .fifo_rst(fifo_rst), .dma_rst(dma_rst));

// file: sdcc_cmd_clk_tb.sv
// Purpose: self-checking bench of the card command/clock block
// Assumes: classic wishbone master, card model on the command line
// Notes  : divider is 0 whenever a frame is sent, so frames stay short
`timescale 1ns/1ps
`include "sdcc_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module sdcc_cmd_clk_tb;
   typedef struct {logic [5:0] idx; logic [31:0] fl; logic rep; logic [7:0] len;
      logic [135:0] rsp; logic [31:0] ri;} sdcc_row_t;
   localparam logic [31:0] k_rsp = 32'h40, k_long = 32'h80, k_crc = 32'h100;
   localparam logic [31:0] k_wait = 32'h2000, k_stop = 32'h4000, k_init = 32'h8000;
   localparam logic [31:0] k_upd = 32'h0020_0000, k_go = 32'h8000_0000;
   logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, busy = 0, rp = 0;
   logic [7:0] adr = 8'h00, len = 8'h30, gap = 8'h02;
   logic [31:0] dat = 32'h0, q, dat_o, arg;
   logic ack, cmd_out, oe_n, cclk, cmd_in, fifo_rst, dma_rst, saw_f = 0, saw_d = 0;
   logic [1:0] src;
   logic [135:0] rsp = '0;
   logic [47:0] got;
   int nfr, nf, n, checks = 0, n_mismatch = 0;
   sdcc_row_t rows[8];
   sdcc_row_t r;
   sdcc_cmd_clk sdcc_cmd_clk_i (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .data_busy(busy), .cmd_in(cmd_in),
      .cmd_out(cmd_out), .cmd_oe_n(oe_n), .cclk_out(cclk), .clk_src(src),
      .fifo_rst(fifo_rst), .dma_rst(dma_rst));
   sdcc_card_model sdcc_card_model_i (.cclk(cclk), .host_bit(cmd_out), .host_oe_n(oe_n),
      .reply_en(rp), .reply(rsp), .reply_len(len), .gap(gap), .cmd_line(cmd_in),
      .got_frame(got), .n_frames(nfr));
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (fifo_rst === 1'b1) saw_f <= 1'b1;
      if (dma_rst === 1'b1) saw_d <= 1'b1;
   end
   // ==========================================================
   // helpers
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin
         @(posedge sys_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = dat_o;
      if (k >= 20) `CHK("ack", 1'b1, ack)
      {cyc, stb, we} <= 3'b000;
      @(posedge sys_clk);
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      int k;
      k = 0;
      do begin
         xfer(a, 1'b0, 32'h0);
         k++;
      end while (q[b] !== v && k < 300);
      `CHK("poll", v, q[b])
   endtask
   task automatic toggles(input int m, output int t);
      logic p;
      t = 0;
      p = cclk;
      repeat (m) begin
         @(posedge sys_clk);
         t += (cclk !== p);
         p = cclk;
      end
   endtask
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
      return c;
   endfunction
   function automatic logic [135:0] sf(input logic [5:0] i, input logic [31:0] a,
      input logic ok, input logic e);
      logic [6:0] c;
      c = crc7({2'b00, i, a});
      return {88'h0, 2'b00, i, a, ok ? c : ~c, e};
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      tally_and_finish();
   end
   // ==========================================================
   // main sequence
   initial begin
      rows[0] = '{6'h08, k_rsp, 1'b1, 8'h30, sf(6'h08, 32'hCAFE0123, 1, 1), 32'h4};
      rows[1] = '{6'h0D, k_rsp | k_crc, 1'b1, 8'h30, sf(6'h0D, 32'h900, 1, 1), 32'h4};
      rows[2] = '{6'h0D, k_rsp | k_crc, 1'b1, 8'h30, sf(6'h0D, 32'h900, 0, 1), 32'h44};
      rows[3] = '{6'h11, k_rsp, 1'b1, 8'h30, sf(6'h11, 32'h12345678, 1, 0), 32'h6};
      rows[4] = '{6'h02, k_rsp | k_long, 1'b1, 8'h88,
         {8'h3F, 120'h0123456789ABCDEFFEDCBA98765432, 8'hAB}, 32'h4};
      rows[5] = '{6'h05, k_rsp, 1'b0, 8'h30, 136'h0, 32'h104};
      rows[6] = '{6'h00, k_init, 1'b0, 8'h30, 136'h0, 32'h4};
      rows[7] = '{6'h0C, k_stop | k_wait, 1'b0, 8'h30, 136'h0, 32'h4};
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("oe_n", 1'b1, oe_n)
      `CHK("cclk", 1'b0, cclk)
      xfer(8'h04, 1'b1, 32'hFFFF_FFFF);
      xfer(8'h04, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      xfer(`SDCC_A_CMD, 1'b0, 32'h0);
      `CHK("issue reg", 32'h0, q)
      $display("reset test done");
      xfer(`SDCC_A_STATUS, 1'b0, 32'h0);
      `CHK("data busy", 1'b0, q[2])
      xfer(`SDCC_A_CLKENA, 1'b1, 32'h1);
      xfer(`SDCC_A_CLKSRC, 1'b1, 32'h2);
      busy <= 1'b1;
      xfer(`SDCC_A_CMD, 1'b1, k_go | k_upd | k_wait);
      repeat (20) @(posedge sys_clk);
      `CHK("src held", 2'h0, src)
      xfer(`SDCC_A_CMD, 1'b0, 32'h0);
      `CHK("start held", 1'b1, q[31])
      busy <= 1'b0;
      poll(`SDCC_A_CMD, 31, 1'b0);
      `CHK("update flag", 1'b0, q[21])
      `CHK("src", 2'h2, src)
      xfer(`SDCC_A_RINTSTS, 1'b0, 32'h0);
      `CHK("silent", 1'b0, q[2])
      toggles(20, n);
      `CHK("cclk runs", 20, n)
      $display("clock update test done");
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         {rp, rsp, len} <= {r.rep, r.rsp, r.len};
         gap <= gap + 8'h06;
         arg = 32'hC0DE_0000 | 32'(i);
         xfer(`SDCC_A_CMDARG, 1'b1, arg);
         xfer(`SDCC_A_CMD, 1'b1, k_go | r.fl | 32'(r.idx));
         poll(`SDCC_A_RINTSTS, 2, 1'b1);
         `CHK("status bits", r.ri, q & 32'h0000_1146)
         `CHK("frame", {2'b01, r.idx, arg, crc7({2'b01, r.idx, arg}), 1'b1}, got)
         xfer(`SDCC_A_CMD, 1'b0, 32'h0);
         `CHK("start", 1'b0, q[31])
         for (int k = 0; k < (r.len == 8'h88 ? 4 : 1) && r.rep; k++) begin
            xfer(8'(`SDCC_A_RESPONSE_WORD_0 + 4 * k), 1'b0, 32'h0);
            `CHK("resp", r.len == 8'h88 ? r.rsp[32*k+:32] : r.rsp[39:8], q)
         end
         xfer(`SDCC_A_RINTSTS, 1'b1, 32'hFFFF_FFFF);
         $display("command row %0d done", i);
      end
      rp <= 1'b0;
      nf = nfr;
      xfer(`SDCC_A_CMD, 1'b1, k_go | 32'h01);
      xfer(`SDCC_A_CMD, 1'b1, k_go | 32'h02);
      xfer(`SDCC_A_STATUS, 1'b0, 32'h0);
      `CHK("buffered", 2'h3, q[1:0])
      xfer(`SDCC_A_CMD, 1'b1, k_go | 32'h03);
      xfer(`SDCC_A_RINTSTS, 1'b0, 32'h0);
      `CHK("lock error", 1'b1, q[12])
      poll(`SDCC_A_STATUS, 1, 1'b0);
      poll(`SDCC_A_STATUS, 0, 1'b0);
      `CHK("frames", nf + 2, nfr)
      `CHK("last index", 6'h02, got[45:40])
      $display("lock error test done");
      xfer(`SDCC_A_RINTSTS, 1'b1, 32'hFFFF_FFFF);
      xfer(`SDCC_A_CLKDIV, 1'b1, 32'h1);
      xfer(`SDCC_A_CMD, 1'b1, k_go | k_upd | k_wait);
      poll(`SDCC_A_CMD, 31, 1'b0);
      toggles(20, n);
      `CHK("cclk divided", 10, n)
      $display("divider test done");
      xfer(`SDCC_A_CLKDIV, 1'b1, 32'h0);
      xfer(`SDCC_A_CLKENA, 1'b1, 32'h0001_0001);
      xfer(`SDCC_A_CMD, 1'b1, k_go | k_upd | k_wait);
      poll(`SDCC_A_CMD, 31, 1'b0);
      repeat (40) @(posedge sys_clk);
      toggles(40, n);
      `CHK("cclk stopped", 0, n)
      nf = nfr;
      xfer(`SDCC_A_CMD, 1'b1, k_go | 32'h07);
      poll(`SDCC_A_RINTSTS, 2, 1'b1);
      `CHK("wake frame", nf + 1, nfr)
      $display("low power test done");
      // dma is idle here, so a combined reset is safe
      xfer(`SDCC_A_CTRL, 1'b1, 32'h7);
      repeat (4) @(posedge sys_clk);
      xfer(`SDCC_A_CTRL, 1'b0, 32'h0);
      `CHK("ctrl", 3'h0, q[2:0])
      `CHK("pulses", 2'b11, {saw_f, saw_d})
      `CHK("src reset", 2'h0, src)
      xfer(`SDCC_A_RINTSTS, 1'b1, 32'hFFFF_FFFF);
      xfer(`SDCC_A_RINTSTS, 1'b0, 32'h0);
      `CHK("cleared", 32'h0, q & 32'h0000_1146)
      $display("reset bits test done");
      tally_and_finish();
   end
endmodule

// file: sdcc_regs.vh
// Purpose : offsets, fields, reset values and timing counts of the card command/clock block
// Assumes : 32-bit classic wishbone, word aligned offsets
// Notes   : definitions only
`ifndef SDCC_REGS_VH
`define SDCC_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define SDCC_A_CTRL      8'h00
`define SDCC_A_CLKDIV    8'h08
`define SDCC_A_CLKSRC    8'h0C
`define SDCC_A_CLKENA    8'h10
`define SDCC_A_CMDARG    8'h28
`define SDCC_A_CMD       8'h2C
`define SDCC_A_RESPONSE_WORD_0     8'h30
`define SDCC_A_RESP1     8'h34
`define SDCC_A_RESP2     8'h38
`define SDCC_A_RESPONSE_WORD_3     8'h3C
`define SDCC_A_RINTSTS   8'h44
`define SDCC_A_STATUS    8'h48

// ==========================================================
// reset-control bits
`define SDCC_CTRL_CTL_RST  0
`define SDCC_CTRL_FIFO_RST 1
`define SDCC_CTRL_DMA_RST  2
// clock enable bits
`define SDCC_ENA_CCLK      0
`define SDCC_ENA_LOWPWR    16
// command_issue fields
`define SDCC_CMD_IDX_HI    5
`define SDCC_CMD_RESP_EXP  6
`define SDCC_CMD_RESP_LONG 7
`define SDCC_CMD_CHK_CRC   8
`define SDCC_CMD_DATA_EXP  9
`define SDCC_CMD_WAIT_PRV  13
`define SDCC_CMD_STOP      14
`define SDCC_CMD_SEND_INIT 15
`define SDCC_CMD_UPD_CLK   21
`define SDCC_CMD_START     31
// raw interrupt status bits (write one to clear)
`define SDCC_RI_FAULT      1
`define SDCC_RI_DONE       2
`define SDCC_RI_RCRC       6
`define SDCC_RI_RTO        8
`define SDCC_RI_HLE        12

// ==========================================================
// reset values and timing counts (in card clock periods)
`define SDCC_RST_CLKDIV    8'h00
`define SDCC_RST_CLKSRC    2'h0
`define SDCC_IDLE_STOP     4'h8
`define SDCC_RTO_CCLK      8'h40
`define SDCC_INIT_CCLK     8'h50
`define SDCC_FRAME_BITS    8'h30
`define SDCC_LONG_BITS     8'h88

`endif
